// ---- rtl/watchdog_timeout_unit.sv ----
// watchdog timeout unit: register port, 8-bit countdown, reset or interrupt on timeout
// assumes one clock, a master that never overlaps read and write strobes,
// and a system that feeds cpu_reset_out back into sys_rst_in
//
// Contract
// - the count source is divided by a fixed 128 and each divided tick steps an 8-bit counter.
// - the counter drops by one per tick and the shortest timeout is 128 source periods.
// - while enabled, a missed reload ends in a processor reset or an interrupt.
// - setting the enable bit loads the timeout constant and starts the countdown.
// - writing 0x55AA to the feed register reloads the counter and cancels the pending timeout.
// - in reset mode an underflow raises a processor reset equal to an external one.
// - register access runs on the bus clock while counting runs on the selected count clock; here both run on clock_in, and source edges only enable the divider.
// - the count clock is one of fast oscillator, slow oscillator, slow crystal or bus clock.
// - a system clock enable can shut register access off to save power.
// - a timeout can happen whenever the unit is enabled and its count source runs.
// - with interrupt mode clear a timeout resets the chip and clears the flag, else interrupts.
// - the 8-bit constant gives a reload count of value plus one and resets to 0xFF.
// - the flag is set by an interrupt timeout and cleared by software writing zero.
`timescale 1ns/1ns
`include "timeout_unit_consts.svh"
module watchdog_timeout_unit
  import timeout_unit_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire reg_req_type reg_req_in,
  input wire logic bus_clock_enable_in,
  input wire logic internal_fast_osc_in,
  input wire logic internal_slow_osc_in,
  input wire logic external_slow_crystal_in,
  output logic [31:0] rd_data_out,
  output logic irq_out,
  output logic cpu_reset_out
);

  logic timeout_unit_enable_q;
  logic timeout_interrupt_mode_q;
  logic timeout_event_flag_q;
  count_clock_select_type count_clock_select_q;
  logic [7:0] timeout_constant_q;
  logic [7:0] count_q;
  logic [`EVT_COUNT-1:0] evt_enable_q;
  logic [`EVT_COUNT-1:0] evt_status;
  logic [`EVT_COUNT-1:0] evt_clear;
  logic [`EVT_COUNT-1:0] evt_set;
  logic evt_pending;
  logic [3:0] reset_hold_q;
  logic [31:0] rd_data_d;
  logic acc_wr;
  logic acc_rd;
  logic cfg_wr;
  logic enable_load;
  logic feed_ok;
  logic reload;
  logic tick;
  logic timeout;

  // gated register clock: no write lands and reads answer zero
  assign acc_wr = reg_req_in.wr && bus_clock_enable_in;
  assign acc_rd = reg_req_in.rd && bus_clock_enable_in;
  assign cfg_wr = acc_wr && (reg_req_in.addr == `OFS_CONFIG);

  // only a rising enable loads; rewriting an enabled config keeps the count
  assign enable_load = cfg_wr && reg_req_in.wdata[`CFG_ENABLE_BIT] && !timeout_unit_enable_q;

  // any other low half-word written to the feed offset is ignored
  assign feed_ok = acc_wr && (reg_req_in.addr == `OFS_FEED)
                   && (reg_req_in.wdata[15:0] == `FEED_PATTERN);
  assign reload = enable_load || (feed_ok && timeout_unit_enable_q);

  // tick generation; single clock domain, so bus writes reach it with no crossing
  count_tick_prescaler u_prescaler (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .count_clock_select_in(count_clock_select_q),
    .internal_fast_osc_in(internal_fast_osc_in),
    .internal_slow_osc_in(internal_slow_osc_in),
    .external_slow_crystal_in(external_slow_crystal_in),
    .run_in(timeout_unit_enable_q),
    .restart_in(reload),
    .tick_out(tick)
  );

  // a feed in the same cycle as the last tick wins and prevents the timeout
  assign timeout = timeout_unit_enable_q && tick && (count_q == 8'h00) && !reload;

  // configuration register; enable and mode are plain storage
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      timeout_unit_enable_q <= 1'b0;
      timeout_interrupt_mode_q <= 1'b0;
    end
    else if (cfg_wr)
    begin
      timeout_unit_enable_q <= reg_req_in.wdata[`CFG_ENABLE_BIT];
      timeout_interrupt_mode_q <= reg_req_in.wdata[`CFG_INTMODE_BIT];
    end
  end

  // flag: interrupt timeout sets it and wins over a clearing write
  // a reset-mode timeout clears it, since the chip is about to restart
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      timeout_event_flag_q <= 1'b0;
    else if (timeout && timeout_interrupt_mode_q)
      timeout_event_flag_q <= 1'b1;
    else if (timeout)
      timeout_event_flag_q <= 1'b0;
    else if (cfg_wr && !reg_req_in.wdata[`CFG_FLAG_BIT])
      timeout_event_flag_q <= 1'b0;
  end

  // source select and constant; constant resets to its longest value
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      count_clock_select_q <= SRC_FAST_OSC;
      timeout_constant_q <= `CONSTANT_RESET;
      evt_enable_q <= '0;
    end
    else if (acc_wr)
    begin
      if (reg_req_in.addr == `OFS_CLKSEL)
        count_clock_select_q <= count_clock_select_type'(reg_req_in.wdata[1:0]);
      if (reg_req_in.addr == `OFS_CONSTANT)
        timeout_constant_q <= reg_req_in.wdata[7:0];
      if (reg_req_in.addr == `OFS_EVT_ENABLE)
        evt_enable_q <= reg_req_in.wdata[`EVT_COUNT-1:0];
    end
  end

  // down-counter: holds the constant, underflow from zero gives value+1 ticks
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      count_q <= `CONSTANT_RESET;
    else if (reload)
      count_q <= timeout_constant_q;
    else if (timeout)
      count_q <= timeout_constant_q;
    else if (timeout_unit_enable_q && tick)
      count_q <= count_q - 8'h01;
  end

  // reset pulse held several cycles so the whole system sees it like a pin reset
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      reset_hold_q <= 4'h0;
    else if (timeout && !timeout_interrupt_mode_q)
      reset_hold_q <= `RESET_PULSE_CYCLES;
    else if (reset_hold_q != 4'h0)
      reset_hold_q <= reset_hold_q - 4'h1;
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      cpu_reset_out <= 1'b0;
    else
      cpu_reset_out <= (timeout && !timeout_interrupt_mode_q) || (reset_hold_q > 4'h1);
  end

  // sticky event bits: timeout and accepted feed
  assign evt_set = {feed_ok, timeout};
  assign evt_clear = (acc_wr && reg_req_in.addr == `OFS_EVT_CLEAR) ?
                     reg_req_in.wdata[`EVT_COUNT-1:0] : '0;

  event_status_bank u_events (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .event_in(evt_set),
    .clear_in(evt_clear),
    .enable_in(evt_enable_q),
    .status_out(evt_status),
    .pending_out(evt_pending)
  );

  // interrupt: the mode flag path or any enabled sticky event
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      irq_out <= 1'b0;
    else
      irq_out <= (timeout_event_flag_q && timeout_interrupt_mode_q) || evt_pending;
  end

  // read mux; the feed and clear registers are write-only and read zero
  always_comb
  begin
    rd_data_d = 32'h0000_0000;
    if (acc_rd)
    begin
      unique case (reg_req_in.addr)
        `OFS_CONFIG: rd_data_d[2:0] = {timeout_event_flag_q, timeout_interrupt_mode_q,
                                        timeout_unit_enable_q};
        `OFS_CLKSEL: rd_data_d[1:0] = count_clock_select_q;
        `OFS_CONSTANT: rd_data_d[7:0] = timeout_constant_q;
        `OFS_EVT_STATUS: rd_data_d[`EVT_COUNT-1:0] = evt_status;
        `OFS_EVT_ENABLE: rd_data_d[`EVT_COUNT-1:0] = evt_enable_q;
        default: rd_data_d = 32'h0000_0000;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      rd_data_out <= 32'h0000_0000;
    else
      rd_data_out <= rd_data_d;
  end

  // checks
  // reset-mode timeout: the pulse opens on the next edge and lasts eight cycles
  sequence s_reset_timeout;
    timeout && !timeout_interrupt_mode_q;
  endsequence

  sequence s_pulse_body;
    cpu_reset_out [*8];
  endsequence

  // interrupt-mode timeout: flag first, the registered interrupt one cycle later
  sequence s_irq_timeout;
    timeout && timeout_interrupt_mode_q;
  endsequence

  sequence s_flag_then_irq;
    timeout_event_flag_q ##1 irq_out;
  endsequence

  sequence s_good_feed;
    feed_ok && timeout_unit_enable_q;
  endsequence

  // loading and reloading of the counter
  a_enable_loads: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    enable_load |=> count_q == $past(timeout_constant_q))
    else $error("enable did not load");
  a_rewrite_keeps: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    cfg_wr && timeout_unit_enable_q && reg_req_in.wdata[`CFG_ENABLE_BIT] && !tick
    |=> count_q == $past(count_q)) else $error("config rewrite reloaded the count");
  a_feed_reloads: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    s_good_feed |=> count_q == $past(timeout_constant_q) && !cpu_reset_out)
    else $error("feed did not reload");
  a_feed_event: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    feed_ok |=> evt_status[`EVT_FEED_BIT])
    else $error("accepted feed not recorded");
  a_bad_feed_ignored: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    acc_wr && reg_req_in.addr == `OFS_FEED && reg_req_in.wdata[15:0] != `FEED_PATTERN
    && !enable_load |-> !reload) else $error("wrong feed value reloaded");
  a_timeout_reloads: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    timeout |=> count_q == $past(timeout_constant_q))
    else $error("counter not reloaded after timeout");

  // stepping and holding of the counter
  a_tick_steps: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    timeout_unit_enable_q && tick && !reload && count_q != 8'h00
    |=> count_q == $past(count_q) - 8'h01)
    else $error("counter not stepped by tick");
  a_disabled_holds: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !timeout_unit_enable_q && !reload |=> count_q == $past(count_q))
    else $error("counter moved while disabled");
  a_disabled_quiet: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !timeout_unit_enable_q |-> !timeout)
    else $error("timeout while disabled");

  // what a timeout does in each mode
  a_reset_pulse: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    s_reset_timeout |=> s_pulse_body ##1 !cpu_reset_out)
    else $error("reset pulse length wrong");
  a_flag_clear_mode: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    s_reset_timeout |=> !timeout_event_flag_q)
    else $error("flag kept in reset mode");
  a_irq_mode: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    s_irq_timeout |=> s_flag_then_irq)
    else $error("interrupt timeout lost");
  a_irq_has_cause: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !(timeout_event_flag_q && timeout_interrupt_mode_q) && !evt_pending |=> !irq_out)
    else $error("interrupt without a cause");

  // flag handling by hardware and software
  a_flag_set_wins: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    timeout && timeout_interrupt_mode_q && cfg_wr |=> timeout_event_flag_q)
    else $error("flag clear beat set");
  a_flag_write_clear: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    cfg_wr && !reg_req_in.wdata[`CFG_FLAG_BIT] && !timeout |=> !timeout_event_flag_q)
    else $error("flag not cleared by write");
  a_flag_drives_irq: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    timeout_event_flag_q && timeout_interrupt_mode_q |=> irq_out)
    else $error("flag did not raise interrupt");

  // register port behaviour
  a_gated_access: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !bus_clock_enable_in |=> rd_data_out == 32'h0000_0000)
    else $error("access while gated");
  a_read_one_cycle: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !acc_rd |=> rd_data_out == 32'h0000_0000)
    else $error("read data outside its cycle");

endmodule : watchdog_timeout_unit

// ---- rtl/timeout_unit_consts.svh ----
// offsets, field positions, reset values and counts of the timeout unit
// assumes byte addresses on an 8-bit register address, 32-bit data words
`ifndef TIMEOUT_UNIT_CONSTS_SVH
`define TIMEOUT_UNIT_CONSTS_SVH

`define OFS_CONFIG 8'h00
`define OFS_CLKSEL 8'h04
`define OFS_CONSTANT 8'h08
`define OFS_FEED 8'h0C
`define OFS_EVT_STATUS 8'h10
`define OFS_EVT_CLEAR 8'h14
`define OFS_EVT_ENABLE 8'h18

`define CFG_ENABLE_BIT 0
`define CFG_INTMODE_BIT 1
`define CFG_FLAG_BIT 2

`define FEED_PATTERN 16'h55AA
`define CONSTANT_RESET 8'hFF
`define PRESCALE_DIV 128
`define PRESCALE_MAX 7'h7F
`define RESET_PULSE_CYCLES 4'h8
`define EVT_COUNT 2
`define EVT_TIMEOUT_BIT 0
`define EVT_FEED_BIT 1

`endif

// ---- rtl/timeout_unit_pkg.sv ----
// types shared by the timeout unit modules
// assumes the constants header sits beside it
package timeout_unit_pkg;

  // one register access request, as the master drives it
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // count clock source codes
  typedef enum logic [1:0] {
    SRC_FAST_OSC = 2'h0,
    SRC_BUS_CLOCK = 2'h1,
    SRC_SLOW_OSC = 2'h2,
    SRC_SLOW_XTAL = 2'h3
  } count_clock_select_type;

endpackage : timeout_unit_pkg

// ---- rtl/count_tick_prescaler.sv ----
// source select and fixed divide-by-128 of the count clock into one-cycle ticks
// assumes oscillator levels are synchronous to clock_in and slower than half its rate
`timescale 1ns/1ns
`include "timeout_unit_consts.svh"
module count_tick_prescaler
  import timeout_unit_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire count_clock_select_type count_clock_select_in,
  input wire logic internal_fast_osc_in,
  input wire logic internal_slow_osc_in,
  input wire logic external_slow_crystal_in,
  input wire logic run_in,
  input wire logic restart_in,
  output logic tick_out
);

  logic [2:0] osc_prev_q;
  logic [2:0] osc_now;
  logic [2:0] osc_rise;
  logic src_edge;
  logic [6:0] div_q;

  assign osc_now = {external_slow_crystal_in, internal_slow_osc_in, internal_fast_osc_in};

  // one edge detector per oscillator input
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_edge
      always_ff @(posedge clock_in or posedge sys_rst_in)
      begin
        if (sys_rst_in)
          osc_prev_q[g] <= 1'b0;
        else
          osc_prev_q[g] <= osc_now[g];
      end
      assign osc_rise[g] = osc_now[g] & ~osc_prev_q[g];
    end
  endgenerate

  // four-way source choice; bus clock gives an edge every cycle
  always_comb
  begin
    unique case (count_clock_select_in)
      SRC_FAST_OSC: src_edge = osc_rise[0];
      SRC_BUS_CLOCK: src_edge = 1'b1;
      SRC_SLOW_OSC: src_edge = osc_rise[1];
      SRC_SLOW_XTAL: src_edge = osc_rise[2];
    endcase
  end

  // restart aligns the first tick a full 128 source edges after a reload
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      div_q <= 7'h00;
    else if (restart_in || !run_in)
      div_q <= 7'h00;
    else if (src_edge)
      div_q <= div_q + 7'h01;
  end

  assign tick_out = run_in && !restart_in && src_edge && (div_q == `PRESCALE_MAX);

  // the divider must wrap to zero on every tick, so ticks stay 128 edges apart
  a_tick_spacing: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    tick_out |=> div_q == 7'h00) else $error("tick not on divider wrap");
  a_tick_stopped: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !run_in |-> !tick_out) else $error("tick while stopped");

endmodule : count_tick_prescaler

// ---- rtl/event_status_bank.sv ----
// sticky event bits with write-one clear, an enable mask and a level interrupt
// assumes event pulses and clear writes come from the same clock
`timescale 1ns/1ns
`include "timeout_unit_consts.svh"
module event_status_bank
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [`EVT_COUNT-1:0] event_in,
  input wire logic [`EVT_COUNT-1:0] clear_in,
  input wire logic [`EVT_COUNT-1:0] enable_in,
  output logic [`EVT_COUNT-1:0] status_out,
  output logic pending_out
);

  // set wins over a clear in the same cycle, so no event is lost
  genvar g;
  generate
    for (g = 0; g < `EVT_COUNT; g++)
    begin : g_bit
      always_ff @(posedge clock_in or posedge sys_rst_in)
      begin
        if (sys_rst_in)
          status_out[g] <= 1'b0;
        else if (event_in[g])
          status_out[g] <= 1'b1;
        else if (clear_in[g])
          status_out[g] <= 1'b0;
      end
    end
  endgenerate

  assign pending_out = |(status_out & enable_in);

  a_set_beats_clear: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    |(event_in & clear_in) |=> |(status_out & $past(event_in & clear_in)))
    else $error("event lost under clear");

endmodule : event_status_bank

// ---- verification/processor_model.sv ----
// processor-side model: oscillator levels and the core's answer to a reset request
// assumes one clock; the external reset comes from the bench
`timescale 1ns/1ns
module processor_model
(
  input wire logic clock_in,
  input wire logic ext_rst_in,
  input wire logic cpu_reset_in,
  output logic sys_rst_out,
  output logic fast_osc_out,
  output logic slow_osc_out,
  output logic crystal_out
);
  logic [4:0] osc_q;
  logic [1:0] hold_q;
  logic prev_q;

  // free-running oscillator levels, periods 4, 16 and 8 cycles
  always_ff @(posedge clock_in or posedge ext_rst_in)
    if (ext_rst_in)
      osc_q <= 5'h00;
    else
      osc_q <= osc_q + 5'h01;
  assign fast_osc_out = osc_q[1];
  assign slow_osc_out = osc_q[3];
  assign crystal_out = osc_q[2];

  // core reset after the request pulse ends, same path as the external reset
  always_ff @(posedge clock_in or posedge ext_rst_in)
    if (ext_rst_in)
    begin
      hold_q <= 2'h0;
      prev_q <= 1'b0;
    end
    else
    begin
      prev_q <= cpu_reset_in;
      if (prev_q && !cpu_reset_in)
        hold_q <= 2'h3;
      else if (hold_q != 2'h0)
        hold_q <= hold_q - 2'h1;
    end
  assign sys_rst_out = ext_rst_in | (hold_q != 2'h0);
endmodule : processor_model

// ---- verification/watchdog_timeout_unit_tb.sv ----
// self-checking bench for the watchdog timeout unit
// assumes the design files are compiled first; one 250 MHz clock
`timescale 1ns/1ns
`include "timeout_unit_consts.svh"
module watchdog_timeout_unit_tb;
  import timeout_unit_pkg::*;
  logic clock_in = 1'b0;
  logic ext_rst = 1'b1;
  logic sys_rst;
  logic bus_en = 1'b1;
  logic fast, slow, xtal;
  reg_req_type req = '0;
  logic [31:0] rdata;
  logic irq, cpu_rst;
  int err_count = 0;
  int tests_run = 0;
  int n;

  processor_model partner (.clock_in(clock_in), .ext_rst_in(ext_rst), .cpu_reset_in(cpu_rst),
    .sys_rst_out(sys_rst), .fast_osc_out(fast), .slow_osc_out(slow), .crystal_out(xtal));
  watchdog_timeout_unit DUT (.clock_in(clock_in), .sys_rst_in(sys_rst), .reg_req_in(req),
    .bus_clock_enable_in(bus_en), .internal_fast_osc_in(fast), .internal_slow_osc_in(slow),
    .external_slow_crystal_in(xtal), .rd_data_out(rdata), .irq_out(irq), .cpu_reset_out(cpu_rst));

  // 4 ns clock
  initial
  begin
    forever #2 clock_in = ~clock_in;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      err_count++;
    end
  endtask : chk

  // one write cycle; returns at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_in);
    req.wr <= 1'b0;
  endtask : wr

  // one read cycle; data looked at only in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_in);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock_in);
    req.rd <= 1'b0;
    #1;
    chk($sformatf("read %h", a), rdata, exp);
  endtask : rd

  // edges until irq or reset request is seen high, bounded
  task automatic wait_hi(input bit on_rst, input int lim, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clock_in);
      #1;
      cnt++;
    end
    while (cnt < lim && ((on_rst ? cpu_rst : irq) !== 1'b1));
  endtask : wait_hi

  // software setup order: source, constant, then enable and mode
  task automatic arm(input logic [1:0] src, input logic [7:0] tc, input logic [31:0] cfg);
    wr(`OFS_CLKSEL, {30'h0, src});
    wr(`OFS_CONSTANT, {24'h0, tc});
    wr(`OFS_CONFIG, cfg);
  endtask : arm

  task automatic disarm();
    wr(`OFS_FEED, {16'h0, `FEED_PATTERN});
    wr(`OFS_CONFIG, 32'h0);
    wr(`OFS_EVT_CLEAR, 32'h3);
  endtask : disarm

  task automatic t_reset_values();
    logic [7:0] ad[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    for (int i = 0; i < 8; i++)
      rd(ad[i], (ad[i] == `OFS_CONSTANT) ? 32'hFF : 32'h0);
    bus_en <= 1'b0;
    wr(`OFS_CONSTANT, 32'h5);
    rd(`OFS_CONSTANT, 32'h0);
    bus_en <= 1'b1;
    rd(`OFS_CONSTANT, 32'hFF);
  endtask : t_reset_values

  // interrupt mode timeout for two constants, flag and status
  task automatic t_irq_timeout();
    logic [7:0] tcs[2] = '{8'h00, 8'h03};
    foreach (tcs[i])
    begin
      arm(2'h1, tcs[i], 32'h3);
      wait_hi(1'b0, 2000, n);
      chk("irq delay", n, (tcs[i] + 1) * 128 + 1);
      chk("no reset", cpu_rst, 1'b0);
      rd(`OFS_CONFIG, 32'h7);
      rd(`OFS_EVT_STATUS, 32'h1);
      disarm();
      repeat (2) @(posedge clock_in);
      #1;
      chk("irq cleared", irq, 1'b0);
    end
  endtask : t_irq_timeout

  // each oscillator source steps the divider at its own rate
  task automatic t_sources();
    logic [1:0] src[3] = '{2'h0, 2'h2, 2'h3};
    int per[3] = '{4, 16, 8};
    foreach (src[i])
    begin
      arm(src[i], 8'h00, 32'h3);
      wait_hi(1'b0, 128 * per[i] + per[i] + 20, n);
      chk("source delay", 32'(n >= 127 * per[i] && n <= 129 * per[i] + 4), 1);
      disarm();
    end
  endtask : t_sources

  // good feed restarts the count, a wrong pattern does not; event irq mask and clear
  task automatic t_feed();
    arm(2'h1, 8'h00, 32'h3);
    repeat (90) @(posedge clock_in);
    wr(`OFS_CONFIG, 32'h3);
    wr(`OFS_FEED, {16'h0, `FEED_PATTERN});
    wr(`OFS_FEED, 32'h000055AB);
    wait_hi(1'b0, 300, n);
    // irq one cycle after the 128th source edge, less the two cycles of the wrong feed
    chk("fed irq delay", n, 127);
    rd(`OFS_EVT_STATUS, 32'h3);
    wr(`OFS_CONFIG, 32'h0);
    repeat (2) @(posedge clock_in);
    #1;
    chk("irq masked", irq, 1'b0);
    wr(`OFS_EVT_ENABLE, 32'h3);
    repeat (2) @(posedge clock_in);
    #1;
    chk("event irq", irq, 1'b1);
    wr(`OFS_EVT_ENABLE, 32'h0);
    repeat (2) @(posedge clock_in);
    #1;
    chk("event masked", irq, 1'b0);
    wr(`OFS_EVT_CLEAR, 32'h3);
    rd(`OFS_EVT_STATUS, 32'h0);
  endtask : t_feed

  // reset mode: request pulse, then the whole unit comes back in reset state
  task automatic t_reset_mode();
    arm(2'h1, 8'h00, 32'h1);
    wait_hi(1'b1, 300, n);
    chk("reset delay", n, 128);
    chk("irq in reset mode", irq, 1'b0);
    n = 0;
    while (cpu_rst === 1'b1 && n < 20)
    begin
      @(posedge clock_in);
      #1;
      n++;
    end
    chk("reset width", n, 8);
    repeat (6) @(posedge clock_in);
    rd(`OFS_CONFIG, 32'h0);
    rd(`OFS_CLKSEL, 32'h0);
  endtask : t_reset_mode

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // main sequence
  initial
  begin
    repeat (12) @(posedge clock_in);
    ext_rst <= 1'b0;
    t_reset_values();
    t_irq_timeout();
    t_sources();
    t_feed();
    t_reset_mode();
    end_sim();
  end

  // hang guard, about five times the expected run
  initial
  begin
    #100000;
    err_count++;
    end_sim();
  end
endmodule : watchdog_timeout_unit_tb
